// ===== bench/arl_line_model.sv
// model of the addressable modules on the two serial lines
`timescale 1ns/1ps
module arl_line_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [3:0] line_cfg,
   output logic [1:0] query,
   output logic [1:0] reply,
   output logic [1:0] poor,
   output logic [1:0] fail,
   output logic [1:0] active
);
   // ---------------------------------------------
   // per line: 0 empty, 1 normal, 2 poor, 3 failed
   // ---------------------------------------------
   logic [3:0] cnt_r;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) cnt_r <= 4'h0;
      else cnt_r <= cnt_r + 4'h1;
   end
   // poor line drops every other pair of reply bursts
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         active[i] = line_cfg[2*i+:2] != 2'h0;
         poor[i] = line_cfg[2*i+:2] == 2'h2;
         fail[i] = line_cfg[2*i+:2] == 2'h3;
         query[i] = active[i] && cnt_r[1:0] == 2'h0;
         reply[i] = active[i] && !fail[i] && cnt_r[1:0] == 2'h2 && !(poor[i] && cnt_r[3]);
      end
   end
endmodule // arl_line_model

// ===== bench/arl_properties.sv
// concurrent checks of the relay and line status block
`timescale 1ns/1ps
module arl_checker #(
   parameter int NUM_EVENTS = 16,
   parameter int NUM_LINES = 2
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic [1:0] mode_selector,
   input wire arl_pkg::arl_mode_t op_mode,
   input wire logic shown_channel_alarm,
   input wire logic display_grayscale,
   input wire logic alarm_relay_one,
   input wire logic alarm_relay_two,
   input wire logic alarm_relay_three,
   input wire logic alarm_relay_four,
   input wire logic fault_relay_coil,
   input wire logic [4:0] relay_led,
   input wire logic [NUM_EVENTS-1:0] fault_events,
   input wire logic [NUM_LINES-1:0] line_comm_fail,
   input wire logic [NUM_LINES-1:0] line_active,
   input wire logic [NUM_LINES-1:0] line_tx_led,
   input wire logic [NUM_LINES-1:0] line_rx_led,
   input wire logic failure_ind
);
   import arl_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // ---------------------------------------------
   // properties
   // ---------------------------------------------
   sequence s_req;
      $rose(avs_read || avs_write);
   endsequence
   sequence s_one_wait;
      avs_waitrequest ##1 !avs_waitrequest;
   endsequence
   AST_ONE_WAIT: assert property (s_req |-> s_one_wait)
      else $error("bus answer not after one wait cycle");
   AST_MODE_SYNC: assert property ($stable(mode_selector) &&
      mode_selector == $past(mode_selector, 2) |-> op_mode == mode_selector)
      else $error("mode does not follow selector");
   AST_RESUME: assert property ((mode_selector == 2'h0)[*3] |-> op_mode == 2'h0)
      else $error("normal mode not resumed");
   AST_GRAY: assert property (display_grayscale == (shown_channel_alarm && op_mode == 2'h0))
      else $error("grayscale mismatch");
   AST_LED: assert property (relay_led == {fault_relay_coil, alarm_relay_four,
      alarm_relay_three, alarm_relay_two, alarm_relay_one})
      else $error("relay led not equal to coil");
   AST_COMM_FAIL: assert property (|(line_comm_fail & line_active) |->
      failure_ind && !fault_relay_coil) else $error("comm fail not signalled");
   AST_FAULT_IDLE: assert property ((fault_events == '0 &&
      (line_comm_fail & line_active) == '0)[*2] |-> fault_relay_coil)
      else $error("fault relay dropped without fault");
   // led registers follow the line state one cycle late, stretched pulses ignored; three cycles of settling allowed
   for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
      AST_RX_OFF: assert property ((line_comm_fail[i] && line_active[i])[*3] |->
         !line_rx_led[i]) else $error("rx led lit on failed line");
      AST_NO_ACTIVE: assert property ((!line_active[i])[*3] |->
         !line_tx_led[i] && !line_rx_led[i]) else $error("led lit on empty line");
   end
endmodule // arl_checker

bind arl_top arl_checker #(.NUM_EVENTS(NUM_EVENTS), .NUM_LINES(NUM_LINES)) arl_checker_inst (
   .clk, .reset_n, .avs_read, .avs_write, .avs_waitrequest, .mode_selector, .op_mode,
   .shown_channel_alarm, .display_grayscale, .alarm_relay_one, .alarm_relay_two,
   .alarm_relay_three, .alarm_relay_four, .fault_relay_coil, .relay_led, .fault_events,
   .line_comm_fail, .line_active, .line_tx_led, .line_rx_led, .failure_ind);

// ===== bench/tb_top.sv
// self-checking bench of the relay and line status block
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
$display("CHECK FAILED at %0t: got %0h want %0h", $time, g, e); end end
module tb_top;
   import arl_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] avs_address = 8'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, rdata;
   logic avs_waitrequest;
   logic [1:0] mode_selector = 2'h0;
   logic ack_key = 1'b0;
   logic [15:0] alarm_events = 16'h0;
   logic [15:0] fault_events = 16'h0;
   logic shown_channel_alarm = 1'b0;
   logic [3:0] line_cfg = 4'h0;
   logic [1:0] line_query_sent, line_reply_rcvd, line_quality_poor, line_comm_fail;
   logic [1:0] line_active, line_tx_led, line_rx_led, seen_tx, seen_rx;
   logic alarm_relay_one, alarm_relay_two, alarm_relay_three, alarm_relay_four;
   logic fault_relay_coil, buzzer, failure_ind, display_grayscale;
   logic [4:0] relay_led;
   arl_mode_t op_mode;
   logic [31:0] rnd = 32'h0000_8104;
   int err_count = 0;
   int total_checks = 0;
   int cycles = 0;
   // ---------------------------------------------
   // instances, clock, timeout
   // ---------------------------------------------
   // one second shortened to 20 cycles to keep timers short
   arl_top #(.CLK_PER_SEC(20), .BLINK_CYC(4)) arl_top_inst (.clk, .reset_n, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .mode_selector,
      .ack_key, .alarm_events, .fault_events, .shown_channel_alarm, .line_query_sent,
      .line_reply_rcvd, .line_quality_poor, .line_comm_fail, .line_active, .alarm_relay_one,
      .alarm_relay_two, .alarm_relay_three, .alarm_relay_four, .fault_relay_coil, .relay_led,
      .line_tx_led, .line_rx_led, .buzzer, .failure_ind, .display_grayscale, .op_mode);
   arl_line_model arl_line_model_inst (.clk, .reset_n, .line_cfg, .query(line_query_sent),
      .reply(line_reply_rcvd), .poor(line_quality_poor), .fail(line_comm_fail),
      .active(line_active));
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         wrap_up();
      end
   end
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic vote(input logic [15:0] ev, input logic [15:0] m, input int x);
      return x != 0 && $countones(ev & m) >= x;
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // request held until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      rdata = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic line_case(input logic [3:0] cfg, input logic [1:0] tx, input logic [1:0] rx);
      line_cfg <= cfg;
      tick(6);
      seen_tx = 2'h0;
      seen_rx = 2'h0;
      repeat (60) begin
         @(posedge clk);
         seen_tx = seen_tx | line_tx_led;
         seen_rx = seen_rx | line_rx_led;
      end
      `CHK(seen_tx, tx);
      `CHK(seen_rx, rx);
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      tick(8);
      reset_n <= 1'b1;
      tick(2);
      shown_channel_alarm <= 1'b1;
      for (int m = 0; m < 3; m++) begin
         mode_selector <= m[1:0];
         tick(4);
         `CHK(op_mode, m[1:0]);
         `CHK(display_grayscale, m == 0);
      end
      mode_selector <= 2'h0;
      shown_channel_alarm <= 1'b0;
      tick(4);
      `CHK(op_mode, 2'h0);
      bus(1'b0, 8'h00, 32'h0);
      `CHK(rdata, 32'h0000_0002);
      bus(1'b0, 8'hF0, 32'h0);
      `CHK(rdata, 32'h0);
      bus(1'b1, 8'h10, 32'h0010_0001);
      bus(1'b1, 8'h20, 32'h0014_0002);
      bus(1'b1, 8'h30, 32'h0020_000C);
      bus(1'b1, 8'h40, 32'h0011_0010);
      bus(1'b1, 8'h48, 32'h000F_000F);
      bus(1'b0, 8'h30, 32'h0);
      `CHK(rdata, 32'h0020_000C);
      `CHK(alarm_relay_two, 1'b1);
      alarm_events <= 16'h0003;
      tick(3);
      `CHK(alarm_relay_one, 1'b1);
      `CHK(alarm_relay_two, 1'b0);
      `CHK(relay_led[1:0], 2'h1);
      alarm_events <= 16'h0;
      tick(3);
      `CHK(alarm_relay_one, 1'b0);
      // bits of relays one, two and four kept clear
      for (int i = 0; i < 12; i++) begin
         rnd = xs(rnd);
         alarm_events <= rnd[15:0] & 16'hFFEC;
         tick(3);
         `CHK(alarm_relay_three, vote(rnd[15:0] & 16'hFFEC, 16'h000C, 2));
      end
      alarm_events <= 16'h0;
      bus(1'b1, 8'h00, 32'h0000_0003);
      fault_events <= 16'h0001;
      tick(3);
      `CHK(alarm_relay_one, 1'b1);
      `CHK(fault_relay_coil, 1'b0);
      fault_events <= 16'h0;
      bus(1'b1, 8'h00, 32'h0000_0002);
      tick(3);
      `CHK(alarm_relay_one, 1'b0);
      bus(1'b1, 8'h14, 32'h0002_0000);
      alarm_events <= 16'h0001;
      tick(3);
      alarm_events <= 16'h0;
      tick(10);
      `CHK(alarm_relay_one, 1'b1);
      tick(80);
      `CHK(alarm_relay_one, 1'b0);
      alarm_events <= 16'h0010;
      tick(3);
      `CHK(alarm_relay_four, 1'b1);
      ack_key <= 1'b1;
      tick(4);
      ack_key <= 1'b0;
      tick(3);
      `CHK(alarm_relay_four, 1'b0);
      `CHK(buzzer, 1'b0);
      tick(400);
      `CHK(alarm_relay_four, 1'b1);
      tick(400);
      `CHK(alarm_relay_four, 1'b0);
      alarm_events <= 16'h0;
      line_case(4'h1, 2'h1, 2'h1);
      line_case(4'hE, 2'h3, 2'h1);
      `CHK(failure_ind, 1'b1);
      `CHK(fault_relay_coil, 1'b0);
      `CHK(buzzer, 1'b1);
      // expression tree: nand, nor, and, and gives event 0 and event 1
      bus(1'b1, 8'h10, 32'h0008_0003);
      bus(1'b1, 8'h18, 32'h5B0F_000F);
      alarm_events <= 16'h0001;
      tick(3);
      `CHK(alarm_relay_one, 1'b0);
      alarm_events <= 16'h0003;
      tick(3);
      `CHK(alarm_relay_one, 1'b1);
      line_cfg <= 4'h0;
      tick(10);
      wrap_up();
   end
endmodule // tb_top

// ===== verilog/arl_defines.svh
// register map, field positions, reset values and timing constants of the relay block
`ifndef ARL_DEFINES_SVH
`define ARL_DEFINES_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define ARL_OFS_CTRL 8'h00
`define ARL_OFS_STATUS 8'h04
`define ARL_OFS_RELAY_BASE 8'h10
`define ARL_RELAY_STRIDE_SH 4
`define ARL_SUB_CFG 2'h0
`define ARL_SUB_TIME_A 2'h1
`define ARL_SUB_TIME_B 2'h2

// ---------------------------------------------------------------
// ctrl fields
// ---------------------------------------------------------------
`define ARL_CTRL_FAULT_AS_ALARM 0
`define ARL_CTRL_BUZZER_EN 1
`define ARL_CTRL_SW_ACK 2
`define ARL_CTRL_RESET 32'h0000_0002

// ---------------------------------------------------------------
// relay cfg fields
// ---------------------------------------------------------------
`define ARL_CFG_BUZZER 16
`define ARL_CFG_LATCHED 17
`define ARL_CFG_ENERGIZED 18
`define ARL_CFG_EXPR 19
`define ARL_CFG_VOTE_LO 20
`define ARL_CFG_VOTE_HI 24
`define ARL_TB_OPS_LO 24
`define ARL_TB_OPS_HI 31
`define ARL_CFG_RESET 32'h0010_0000
`define ARL_TIME_A_RESET 32'h0000_0000
`define ARL_TIME_B_RESET 32'h000F_000F

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define ARL_CLK_HZ 10000000
`define ARL_TIME_MAX_S 10'd900
`define ARL_TIME_MIN_BUZ_S 10'd15
`define ARL_FAST_BLINK_MS 50
`define ARL_FAST_BLINK_CYC ((`ARL_CLK_HZ / 1000) * `ARL_FAST_BLINK_MS)
`define ARL_MODE_NORMAL 2'h0
`define ARL_MODE_CONFIG 2'h1
`define ARL_MODE_UPDATE 2'h2

`endif

// ===== verilog/arl_pkg.sv
// types shared by the alarm relay and line status block
package arl_pkg;
   typedef enum logic [3:0] {
      ARL_IDLE = 4'b0001,
      ARL_DELAY = 4'b0010,
      ARL_ON = 4'b0100,
      ARL_ACKED = 4'b1000
   } arl_state_t;
   typedef enum logic [1:0] {
      ARL_OP_OR = 2'h0,
      ARL_OP_AND = 2'h1,
      ARL_OP_NOR = 2'h2,
      ARL_OP_NAND = 2'h3
   } arl_op_t;
   typedef logic [1:0] arl_mode_t;
endpackage

// ===== verilog/arl_top.sv
// alarm relay management, fault relay, line status leds and mode selector decode
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "arl_defines.svh"

module arl_top #(
   parameter int NUM_EVENTS = 16,
   parameter int NUM_LINES = 2,
   parameter int CLK_PER_SEC = `ARL_CLK_HZ,
   parameter int BLINK_CYC = `ARL_FAST_BLINK_CYC
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [1:0] mode_selector,
   input wire logic ack_key,
   input wire logic [NUM_EVENTS-1:0] alarm_events,
   input wire logic [NUM_EVENTS-1:0] fault_events,
   input wire logic shown_channel_alarm,
   input wire logic [NUM_LINES-1:0] line_query_sent,
   input wire logic [NUM_LINES-1:0] line_reply_rcvd,
   input wire logic [NUM_LINES-1:0] line_quality_poor,
   input wire logic [NUM_LINES-1:0] line_comm_fail,
   input wire logic [NUM_LINES-1:0] line_active,
   output logic alarm_relay_one,
   output logic alarm_relay_two,
   output logic alarm_relay_three,
   output logic alarm_relay_four,
   output logic fault_relay_coil,
   output logic [4:0] relay_led,
   output logic [NUM_LINES-1:0] line_tx_led,
   output logic [NUM_LINES-1:0] line_rx_led,
   output logic buzzer,
   output logic failure_ind,
   output logic display_grayscale,
   output arl_pkg::arl_mode_t op_mode
);
   import arl_pkg::*;

   // ---------------------------------------------------------------
   // helper functions
   // ---------------------------------------------------------------
   function automatic logic [4:0] popcount(input logic [15:0] v);
      logic [4:0] c;
      c = 5'h00;
      for (int i = 0; i < 16; i++) begin
         c = c + {4'h0, v[i]};
      end
      return c;
   endfunction

   function automatic logic apply_op(input logic a, input logic b, input logic [1:0] op);
      logic r;
      r = 1'b0;
      unique case (op)
         ARL_OP_OR: r = a | b;
         ARL_OP_AND: r = a & b;
         ARL_OP_NOR: r = ~(a | b);
         ARL_OP_NAND: r = ~(a & b);
      endcase
      return r;
   endfunction

   // four nesting levels: 16 leaves folded pairwise, one operator per level
   function automatic logic expr_eval(input logic [15:0] ev, input logic [15:0] mask,
                                      input logic [7:0] ops);
      logic [15:0] node;
      logic idle_leaf;
      idle_leaf = ops[0];
      for (int i = 0; i < 16; i++) begin
         node[i] = mask[i] ? ev[i] : idle_leaf;
      end
      for (int l = 0; l < 4; l++) begin
         for (int i = 0; i < (8 >> l); i++) begin
            node[i] = apply_op(node[2*i], node[2*i+1], ops[2*l +: 2]);
         end
      end
      return node[0];
   endfunction

   function automatic logic [9:0] clamp_time(input logic [9:0] v, input logic [9:0] lo);
      logic [9:0] r;
      r = v;
      if (v > `ARL_TIME_MAX_S) begin
         r = `ARL_TIME_MAX_S;
      end
      if (v < lo) begin
         r = lo;
      end
      return r;
   endfunction

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [1:0] mode_s1_r, mode_s2_r;
   logic [2:0] ack_sync_r;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_s1_r <= 2'h0;
         mode_s2_r <= 2'h0;
         ack_sync_r <= 3'h0;
      end else begin
         mode_s1_r <= mode_selector;
         mode_s2_r <= mode_s1_r;
         ack_sync_r <= {ack_sync_r[1:0], ack_key};
      end
   end

   logic mode_normal;
   assign mode_normal = (mode_s2_r == `ARL_MODE_NORMAL);
   assign op_mode = mode_s2_r;

   // ---------------------------------------------------------------
   // registers and bus slave
   // ---------------------------------------------------------------
   logic [31:0] ctrl_r, ctrl_nxt;
   logic [31:0] cfg_r [4], cfg_nxt [4];
   logic [31:0] tima_r [4], tima_nxt [4];
   logic [31:0] timb_r [4], timb_nxt [4];
   logic resp_r, resp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic sw_ack_r, sw_ack_nxt;
   logic [3:0] relay_on;

   logic bus_req, bus_take;
   logic relay_hit;
   logic [1:0] relay_idx;
   logic [1:0] sub_idx;
   assign bus_req = avs_read | avs_write;
   assign bus_take = bus_req & resp_r;
   assign avs_waitrequest = bus_req & ~resp_r;
   assign avs_readdata = rdata_r;
   assign relay_hit = (avs_address >= `ARL_OFS_RELAY_BASE) &&
                      (avs_address < (`ARL_OFS_RELAY_BASE + 8'h40)) &&
                      (avs_address[3:2] != 2'h3);
   assign relay_idx = 2'((avs_address - `ARL_OFS_RELAY_BASE) >> `ARL_RELAY_STRIDE_SH);
   assign sub_idx = avs_address[3:2];

   always_comb begin
      ctrl_nxt = ctrl_r;
      cfg_nxt = cfg_r;
      tima_nxt = tima_r;
      timb_nxt = timb_r;
      sw_ack_nxt = 1'b0;
      resp_nxt = bus_req & ~resp_r;
      rdata_nxt = rdata_r;
      if (bus_req && !resp_r) begin
         rdata_nxt = 32'h0000_0000;
         if (avs_address == `ARL_OFS_CTRL) begin
            rdata_nxt = ctrl_r;
         end else if (avs_address == `ARL_OFS_STATUS) begin
            rdata_nxt = {18'h0, line_comm_fail[1:0], buzzer, fault_relay_coil,
                         relay_led[3:0], relay_on, mode_s2_r};
         end else if (relay_hit) begin
            unique case (sub_idx)
               `ARL_SUB_CFG: rdata_nxt = cfg_r[relay_idx];
               `ARL_SUB_TIME_A: rdata_nxt = tima_r[relay_idx];
               default: rdata_nxt = timb_r[relay_idx];
            endcase
         end
      end
      if (bus_take && avs_write) begin
         if (avs_address == `ARL_OFS_CTRL) begin
            ctrl_nxt = {30'h0, avs_writedata[1:0]};
            sw_ack_nxt = avs_writedata[`ARL_CTRL_SW_ACK];
         end else if (relay_hit) begin
            unique case (sub_idx)
               `ARL_SUB_CFG: cfg_nxt[relay_idx] = avs_writedata;
               `ARL_SUB_TIME_A: tima_nxt[relay_idx] = {6'h0,
                  clamp_time(avs_writedata[25:16], 10'd0), 6'h0,
                  clamp_time(avs_writedata[9:0], 10'd0)};
               // limitation: level-0 ops share bits 25:24 with the reactivation time
               default: timb_nxt[relay_idx] = {avs_writedata[31:26],
                  clamp_time(avs_writedata[25:16], `ARL_TIME_MIN_BUZ_S), 6'h0,
                  clamp_time(avs_writedata[9:0], `ARL_TIME_MIN_BUZ_S)};
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_r <= `ARL_CTRL_RESET;
         for (int i = 0; i < 4; i++) begin
            cfg_r[i] <= `ARL_CFG_RESET;
            tima_r[i] <= `ARL_TIME_A_RESET;
            timb_r[i] <= `ARL_TIME_B_RESET;
         end
         resp_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         sw_ack_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         cfg_r <= cfg_nxt;
         tima_r <= tima_nxt;
         timb_r <= timb_nxt;
         resp_r <= resp_nxt;
         rdata_r <= rdata_nxt;
         sw_ack_r <= sw_ack_nxt;
      end
   end

   // ---------------------------------------------------------------
   // ticks, blink sources, acknowledge
   // ---------------------------------------------------------------
   logic [31:0] sec_cnt_r, sec_cnt_nxt;
   logic [31:0] fast_cnt_r, fast_cnt_nxt;
   logic sec_tick, fast_tick;
   logic slow_blink_r, slow_blink_nxt;
   logic [7:0] lfsr_r, lfsr_nxt;
   logic ack_pulse;

   assign sec_tick = (sec_cnt_r == 32'(CLK_PER_SEC - 1));
   assign fast_tick = (fast_cnt_r == 32'(BLINK_CYC - 1));
   assign ack_pulse = (ack_sync_r[1] & ~ack_sync_r[2]) | sw_ack_r;

   always_comb begin
      sec_cnt_nxt = sec_tick ? 32'h0 : sec_cnt_r + 32'h1;
      fast_cnt_nxt = fast_tick ? 32'h0 : fast_cnt_r + 32'h1;
      // toggle twice a second so one full blink fits in each second
      slow_blink_nxt = (sec_tick || sec_cnt_r == 32'(CLK_PER_SEC / 2 - 1)) ? ~slow_blink_r
                                                                          : slow_blink_r;
      // pseudo random pattern gives the irregular look without a second timer
      lfsr_nxt = fast_tick ? {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]}
                           : lfsr_r;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sec_cnt_r <= 32'h0;
         fast_cnt_r <= 32'h0;
         slow_blink_r <= 1'b0;
         lfsr_r <= 8'h01;
      end else begin
         sec_cnt_r <= sec_cnt_nxt;
         fast_cnt_r <= fast_cnt_nxt;
         slow_blink_r <= slow_blink_nxt;
         lfsr_r <= lfsr_nxt;
      end
   end

   // ---------------------------------------------------------------
   // alarm relays
   // ---------------------------------------------------------------
   logic [15:0] eff_events;
   logic [3:0] relay_cond;
   arl_state_t rstate_r [4], rstate_nxt [4];
   logic [9:0] rtime_r [4], rtime_nxt [4];

   assign eff_events = alarm_events[15:0] |
                       (fault_events[15:0] & {16{ctrl_r[`ARL_CTRL_FAULT_AS_ALARM]}});

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (cfg_r[i][`ARL_CFG_EXPR]) begin
            relay_cond[i] = expr_eval(eff_events, cfg_r[i][15:0],
                                      timb_r[i][`ARL_TB_OPS_HI:`ARL_TB_OPS_LO]);
         end else begin
            relay_cond[i] = (cfg_r[i][`ARL_CFG_VOTE_HI:`ARL_CFG_VOTE_LO] != 5'h0) &&
                            (popcount(eff_events & cfg_r[i][15:0]) >=
                             cfg_r[i][`ARL_CFG_VOTE_HI:`ARL_CFG_VOTE_LO]);
         end
      end
   end

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         logic inhibit_done;
         inhibit_done = (rtime_r[i] >= tima_r[i][25:16]);
         rstate_nxt[i] = rstate_r[i];
         rtime_nxt[i] = (sec_tick && rtime_r[i] != 10'h3FF) ? rtime_r[i] + 10'h1 : rtime_r[i];
         unique case (rstate_r[i])
            ARL_IDLE: begin
               if (relay_cond[i]) begin
                  rstate_nxt[i] = (tima_r[i][9:0] == 10'h0) ? ARL_ON : ARL_DELAY;
                  rtime_nxt[i] = 10'h0;
               end
            end
            ARL_DELAY: begin
               if (!relay_cond[i]) begin
                  rstate_nxt[i] = ARL_IDLE;
               end else if (rtime_r[i] >= tima_r[i][9:0]) begin
                  rstate_nxt[i] = ARL_ON;
                  rtime_nxt[i] = 10'h0;
               end
            end
            ARL_ON: begin
               if (cfg_r[i][`ARL_CFG_BUZZER] && inhibit_done &&
                   (ack_pulse || rtime_r[i] >= timb_r[i][9:0])) begin
                  rstate_nxt[i] = ARL_ACKED;
                  rtime_nxt[i] = 10'h0;
               end else if (!relay_cond[i] && inhibit_done &&
                            (!cfg_r[i][`ARL_CFG_LATCHED] || ack_pulse)) begin
                  rstate_nxt[i] = ARL_IDLE;
               end
            end
            ARL_ACKED: begin
               if (!relay_cond[i]) begin
                  rstate_nxt[i] = ARL_IDLE;
               end else if (rtime_r[i] >= timb_r[i][25:16]) begin
                  rstate_nxt[i] = ARL_ON;
                  rtime_nxt[i] = 10'h0;
               end
            end
         endcase
         if (!mode_normal) begin
            rstate_nxt[i] = ARL_IDLE;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < 4; i++) begin
            rstate_r[i] <= ARL_IDLE;
            rtime_r[i] <= 10'h0;
         end
      end else begin
         rstate_r <= rstate_nxt;
         rtime_r <= rtime_nxt;
      end
   end

   // ---------------------------------------------------------------
   // coils, leds, buzzer
   // ---------------------------------------------------------------
   logic [3:0] coil;
   logic any_fault, any_alarm_rise;
   logic [15:0] alarm_d_r;
   logic comm_fail_any, comm_fail_d_r;
   logic buzz_r, buzz_nxt;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         relay_on[i] = (rstate_r[i] == ARL_ON);
         coil[i] = relay_on[i] ^ cfg_r[i][`ARL_CFG_ENERGIZED];
      end
   end

   assign comm_fail_any = |(line_comm_fail & line_active);
   assign any_fault = (|fault_events) | comm_fail_any;
   assign any_alarm_rise = |(eff_events & ~alarm_d_r) | (comm_fail_any & ~comm_fail_d_r);
   // fault coil held energized while healthy, so power loss also trips it
   assign fault_relay_coil = ~any_fault;
   assign alarm_relay_one = coil[0];
   assign alarm_relay_two = coil[1];
   assign alarm_relay_three = coil[2];
   assign alarm_relay_four = coil[3];
   assign relay_led = {fault_relay_coil, coil};
   assign failure_ind = any_fault;
   assign buzzer = buzz_r & ctrl_r[`ARL_CTRL_BUZZER_EN];
   assign display_grayscale = shown_channel_alarm & mode_normal;

   // new event wins over a same-cycle acknowledge
   assign buzz_nxt = any_alarm_rise ? 1'b1 : (ack_pulse ? 1'b0 : buzz_r);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         alarm_d_r <= 16'h0;
         comm_fail_d_r <= 1'b0;
         buzz_r <= 1'b0;
      end else begin
         alarm_d_r <= eff_events;
         comm_fail_d_r <= comm_fail_any;
         buzz_r <= buzz_nxt;
      end
   end

   // ---------------------------------------------------------------
   // line status leds
   // ---------------------------------------------------------------
   logic [NUM_LINES-1:0] tx_st_r, tx_st_nxt, rx_st_r, rx_st_nxt;
   logic [NUM_LINES-1:0] tx_led_r, tx_led_nxt, rx_led_r, rx_led_nxt;

   always_comb begin
      for (int l = 0; l < NUM_LINES; l++) begin
         // stretch each query/reply until the next fast blink tick so it is visible
         tx_st_nxt[l] = line_query_sent[l] ? 1'b1 : (fast_tick ? 1'b0 : tx_st_r[l]);
         rx_st_nxt[l] = line_reply_rcvd[l] ? 1'b1 : (fast_tick ? 1'b0 : rx_st_r[l]);
         if (!line_active[l]) begin
            tx_led_nxt[l] = 1'b0;
            rx_led_nxt[l] = 1'b0;
         end else if (line_comm_fail[l]) begin
            tx_led_nxt[l] = slow_blink_r;
            rx_led_nxt[l] = 1'b0;
         end else if (line_quality_poor[l]) begin
            tx_led_nxt[l] = lfsr_r[0] & tx_st_r[l];
            rx_led_nxt[l] = lfsr_r[2] & rx_st_r[l];
         end else begin
            tx_led_nxt[l] = tx_st_r[l];
            rx_led_nxt[l] = rx_st_r[l];
         end
      end
   end

   assign line_tx_led = tx_led_r;
   assign line_rx_led = rx_led_r;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_st_r <= '0;
         rx_st_r <= '0;
         tx_led_r <= '0;
         rx_led_r <= '0;
      end else begin
         tx_st_r <= tx_st_nxt;
         rx_st_r <= rx_st_nxt;
         tx_led_r <= tx_led_nxt;
         rx_led_r <= rx_led_nxt;
      end
   end
endmodule // arl_top
